// ===== dv/pmx_pad_model.sv
`timescale 1ns/1ps
module pmx_pad_model (
    input wire logic i_ref_clk,
    input wire logic [7:0] i_out, i_oe,
    output logic [7:0] o_pin,
    output logic [7:0] o_seg = 8'h5a
);
    always @(posedge i_ref_clk) o_seg <= o_seg + 8'h3b;
    // Released pads show the inverse so a stale value never passes
    assign o_pin = i_out ^ ~i_oe;
endmodule

// ===== dv/pmx_port8_monitor.sv
`timescale 1ns/1ps
module pmx_port8_monitor import pmx_pkg::*; (
    input wire logic i_ref_clk, i_rst_n, o_segment_mode,
    input pmx_mode_e i_mode,
    input wire logic [3:0] i_segment_select_field,
    input pmx_byte_t i_port8_direction_bits, i_port8_data, o_port8_pin, o_port8_pin_oe
);
    wire r = i_mode[0] | i_mode[1];
    wire g = i_segment_select_field[3:1] == 3'h0;
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (!i_rst_n);
    a_gpio_oe: assert property (r && g |=> o_port8_pin_oe == $past(i_port8_direction_bits))
        else $error("oe");
    a_gpio_out: assert property (r && g |=>
        o_port8_pin == ($past(i_port8_data) & o_port8_pin_oe)) else $error("pin");
    a_seg_drive: assert property (r && !g |=> &o_port8_pin_oe) else $error("seg");
    a_mode_flag: assert property (r |=> o_segment_mode != $past(g)) else $error("flag");
    a_standby_hiz: assert property (i_mode[5] |=> o_port8_pin_oe == 8'h0) else $error("hiz");
    a_sleep_hold: assert property (|i_mode[4:2] |=> $stable(o_port8_pin)) else $error("hold");
    c_gpio: cover property (r && g);
    c_seg: cover property (r && !g);
    c_hold: cover property (i_mode[4]);
endmodule

// ===== dv/tb_top.sv
`timescale 1ns/1ps
`define CMP(n, e, s) begin compares++; if ((s) !== (e)) begin failures++; \
    $display("BAD %s exp %h got %h", n, e, s); end end
module tb_top;
    import pmx_pkg::*;
    logic i_ref_clk = 0, i_rst_n = 0, o_segment_mode, e_seg = 1'b0;
    pmx_mode_e i_mode = PMX_ACTIVE;
    logic [3:0] i_segment_select_field = 4'h0;
    pmx_byte_t i_port8_direction_bits = 8'h0, i_port8_data = 8'h0, i_lcd_segment_output;
    pmx_byte_t i_port8_pin, o_port8_pin, o_port8_pin_oe, o_port8_pin_state, e = 8'h0;
    pmx_byte_t e_pin = 8'h0, p_pin = 8'h0, p_oe = 8'h0, mask;
    logic [31:0] x = 32'h1571;
    int failures = 0, compares = 0, cyc = 0, stab = 0;
    function automatic logic [31:0] xorshift(logic [31:0] v);
        v ^= v << 13;
        v ^= v >> 17;
        v ^= v << 5;
        return v;
    endfunction
    function automatic pmx_byte_t want(pmx_byte_t p);
        if (i_mode[5] || !i_rst_n) return 8'h0;
        if (!(i_mode[0] | i_mode[1])) return p;
        return i_segment_select_field[3:1] ? 8'hff : i_port8_direction_bits;
    endfunction
    function automatic pmx_byte_t want_pin(pmx_byte_t p);
        if (i_mode[5] || !i_rst_n) return 8'h0;
        if (!(i_mode[0] | i_mode[1])) return p;
        if (i_segment_select_field[3:1] != 3'h0) return i_lcd_segment_output;
        return i_port8_data & i_port8_direction_bits;
    endfunction
    initial forever #4 i_ref_clk = ~i_ref_clk;
    pmx_port8_mux dut (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_mode(i_mode),
        .i_segment_select_field(i_segment_select_field),
        .i_port8_direction_bits(i_port8_direction_bits), .i_port8_data(i_port8_data),
        .i_lcd_segment_output(i_lcd_segment_output), .i_port8_pin(i_port8_pin),
        .o_port8_pin(o_port8_pin), .o_port8_pin_oe(o_port8_pin_oe),
        .o_port8_pin_state(o_port8_pin_state), .o_segment_mode(o_segment_mode));
    pmx_pad_model pad (.i_ref_clk, .i_out(o_port8_pin), .i_oe(o_port8_pin_oe),
        .o_pin(i_port8_pin), .o_seg(i_lcd_segment_output));
    always @(posedge i_ref_clk) begin
        x = xorshift(x);
        cyc <= cyc + 1;
        // Early cycles walk the select codes across the gpio boundary
        i_mode <= cyc < 9 ? PMX_ACTIVE : pmx_mode_e'(6'h01 << x[2:0] % 3'h6);
        i_segment_select_field <= cyc < 9 ? cyc[3:0] - 4'h4 : x[11:8];
        {i_port8_direction_bits, i_port8_data} <= x[31:16];
    end
    always @(negedge i_ref_clk) begin
        // Released pads reach the readback only after the sync and its register
        stab = (!i_rst_n || e != p_oe || e_pin != p_pin) ? 0 : stab + 1;
        mask = stab >= 6 ? 8'hff : e;
        `CMP("oe", e, o_port8_pin_oe)
        `CMP("pin", e_pin, o_port8_pin)
        `CMP("seg", e_seg, o_segment_mode)
        `CMP("state", (e_pin ^ ~e) & mask, o_port8_pin_state & mask)
        p_oe = e;
        p_pin = e_pin;
        e = want(e);
        e_pin = want_pin(e_pin);
        if (!i_rst_n) e_seg = 1'b0;
        else if (i_mode[0] | i_mode[1]) e_seg = |i_segment_select_field[3:1];
        if (cyc > 3000) begin
            failures++;
            tally_and_finish();
        end
    end
    initial begin
        repeat (2) @(posedge i_ref_clk);
        i_rst_n <= 1'b1;
        repeat (2000) @(posedge i_ref_clk);
        $display("random mode run done");
        tally_and_finish();
    end
    task automatic tally_and_finish();
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
endmodule
bind pmx_port8_mux pmx_port8_monitor mon (.*);

// ===== pkg/pmx_consts.svh
`ifndef PMX_CONSTS_SVH
`define PMX_CONSTS_SVH
`define PMX_NPINS 8
`define PMX_SEL_W 4
`define PMX_GPIO_MASK 4'he
`define PMX_GPIO_CODE 4'h0
`define PMX_SEG_BASE 25
`endif

// ===== pkg/pmx_pin_if.sv
`timescale 1ns/1ps
interface pmx_pin_if;
    logic [7:0] out;
    logic [7:0] oe;
    modport src (output out, output oe);
    modport dst (input out, input oe);
endinterface

// ===== pkg/pmx_pkg.sv
package pmx_pkg;
    typedef enum logic [5:0] {
        PMX_ACTIVE    = 6'h01,
        PMX_SUBACTIVE = 6'h02,
        PMX_SLEEP     = 6'h04,
        PMX_SUBSLEEP  = 6'h08,
        PMX_WATCH     = 6'h10,
        PMX_STANDBY   = 6'h20
    } pmx_mode_e;
    typedef logic [7:0] pmx_byte_t;
endpackage

// ===== rtl/pmx_port8_mux.sv
`timescale 1ns/1ps
`include "pmx_consts.svh"
// How it works
// - Select 000x: direction bit picks in/out
// - Other selects: pin drives LCD segment
// - Reset and standby: all pins high impedance
// - Sleep, subsleep, watch: pins hold state
// - Active, subactive: pins follow settings
module pmx_port8_mux (
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    input pmx_pkg::pmx_mode_e i_mode,
    input wire logic [`PMX_SEL_W-1:0] i_segment_select_field,
    input pmx_pkg::pmx_byte_t i_port8_direction_bits,
    input pmx_pkg::pmx_byte_t i_port8_data,
    input pmx_pkg::pmx_byte_t i_lcd_segment_output,
    input pmx_pkg::pmx_byte_t i_port8_pin,
    output pmx_pkg::pmx_byte_t o_port8_pin,
    output pmx_pkg::pmx_byte_t o_port8_pin_oe,
    output pmx_pkg::pmx_byte_t o_port8_pin_state,
    output logic o_segment_mode
);
    import pmx_pkg::*;

    // Coarse power-mode groups: what the pins may do this cycle
    typedef enum logic [2:0] {
        PMX_GRP_RUN = 3'h1,
        PMX_GRP_HOLD = 3'h2,
        PMX_GRP_OFF = 3'h4
    } pmx_grp_e;

    // Role of one shared pin under the current select and direction bit
    typedef enum logic [2:0] {
        PMX_ROLE_IN = 3'h1,
        PMX_ROLE_OUT = 3'h2,
        PMX_ROLE_SEG = 3'h4
    } pmx_role_e;

    typedef struct packed {
        pmx_byte_t pin;
        pmx_byte_t oe;
        logic lcd_segment_output;
        pmx_byte_t state;
    } pmx_top_s;

    pmx_top_s st_r;
    pmx_top_s st_nxt;
    pmx_pin_if drv ();
    pmx_byte_t pin_sync;
    pmx_grp_e grp;
    logic gpio_sel;
    pmx_role_e role [`PMX_NPINS];

    function automatic logic is_gpio(input logic [`PMX_SEL_W-1:0] sel);
        return (sel & `PMX_GPIO_MASK) == `PMX_GPIO_CODE;
    endfunction

    // Any code that is not one-hot lands in the off group: a released
    // pin is the safe answer to a mode the block does not know
    function automatic pmx_grp_e mode_group(input pmx_mode_e mode);
        pmx_grp_e grp_v;
        grp_v = PMX_GRP_OFF;
        unique case (mode)
            PMX_ACTIVE, PMX_SUBACTIVE: begin
                grp_v = PMX_GRP_RUN;
            end
            PMX_SLEEP, PMX_SUBSLEEP, PMX_WATCH: begin
                grp_v = PMX_GRP_HOLD;
            end
            PMX_STANDBY: begin
                grp_v = PMX_GRP_OFF;
            end
            default: begin
                grp_v = PMX_GRP_OFF;
            end
        endcase
        return grp_v;
    endfunction

    function automatic pmx_role_e pin_role(input logic gpio, input logic dir_bit);
        pmx_role_e role_v;
        if (!gpio) begin
            role_v = PMX_ROLE_SEG;
        end else if (dir_bit) begin
            role_v = PMX_ROLE_OUT;
        end else begin
            role_v = PMX_ROLE_IN;
        end
        return role_v;
    endfunction

    function automatic logic pin_enable(input pmx_role_e role_v);
        logic en;
        en = 1'b0;
        unique case (role_v)
            PMX_ROLE_IN: begin
                en = 1'b0;
            end
            PMX_ROLE_OUT: begin
                en = 1'b1;
            end
            PMX_ROLE_SEG: begin
                en = 1'b1;
            end
        endcase
        return en;
    endfunction

    function automatic logic pin_level(
        input pmx_role_e role_v,
        input logic data_bit,
        input logic seg_bit
    );
        logic lvl;
        lvl = 1'b0;
        unique case (role_v)
            PMX_ROLE_IN: begin
                // Output latch stays low while the pin listens
                lvl = 1'b0;
            end
            PMX_ROLE_OUT: begin
                lvl = data_bit;
            end
            PMX_ROLE_SEG: begin
                lvl = seg_bit;
            end
        endcase
        return lvl;
    endfunction

    // Driven pins read back their own drive, released pins the pad level
    function automatic pmx_byte_t read_level(
        input pmx_byte_t sync_v,
        input pmx_byte_t pin_v,
        input pmx_byte_t oe_v
    );
        pmx_byte_t rd;
        rd = '0;
        for (int n = 0; n < `PMX_NPINS; n++) begin
            if (oe_v[n]) begin
                rd[n] = pin_v[n];
            end else begin
                rd[n] = sync_v[n];
            end
        end
        return rd;
    endfunction

    // The flag remembers the last functional choice through hold and off
    function automatic logic seg_flag(
        input pmx_grp_e grp_v,
        input logic gpio,
        input logic prev
    );
        logic flag;
        flag = prev;
        if (grp_v == PMX_GRP_RUN) begin
            flag = !gpio;
        end
        return flag;
    endfunction

    // Agreement of two late stages costs a cycle but never passes a one-sample glitch
    pmx_sync #(.W(`PMX_NPINS)) u_sync (
        .i_ref_clk(i_ref_clk),
        .i_rst_n(i_rst_n),
        .i_async(i_port8_pin),
        .o_sync(pin_sync)
    );

    assign gpio_sel = is_gpio(i_segment_select_field);
    assign grp = mode_group(i_mode);

    // Per-pin role; the direction bit only matters in general-purpose mode
    always_comb begin
        for (int n = 0; n < `PMX_NPINS; n++) begin
            role[n] = pin_role(gpio_sel, i_port8_direction_bits[n]);
        end
    end

    // Functional drive computed every cycle, used only when the mode allows
    always_comb begin
        drv.oe = '0;
        drv.out = '0;
        for (int n = 0; n < `PMX_NPINS; n++) begin
            // Pin n carries segment bit n of i_lcd_segment_output, with no base offset
            drv.oe[n] = pin_enable(role[n]);
            drv.out[n] = pin_level(role[n], i_port8_data[n], i_lcd_segment_output[n]);
        end
    end

    always_comb begin
        st_nxt = st_r;
        unique case (grp)
            PMX_GRP_RUN: begin
                st_nxt.pin = drv.out;
                st_nxt.oe = drv.oe;
            end
            PMX_GRP_HOLD: begin
                // Pins keep whatever they showed before the mode was entered
                st_nxt.pin = st_r.pin;
                st_nxt.oe = st_r.oe;
            end
            PMX_GRP_OFF: begin
                st_nxt.oe = '0;
                st_nxt.pin = '0;
            end
        endcase
        st_nxt.lcd_segment_output = seg_flag(grp, gpio_sel, st_r.lcd_segment_output);
        // Readback registered so the port never shows a combinational glitch
        st_nxt.state = read_level(pin_sync, st_nxt.pin, st_nxt.oe);
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign o_port8_pin = st_r.pin;
    assign o_port8_pin_oe = st_r.oe;
    assign o_segment_mode = st_r.lcd_segment_output;
    assign o_port8_pin_state = st_r.state;
endmodule

// ===== rtl/pmx_sync.sv
`timescale 1ns/1ps
module pmx_sync #(
    parameter int W = 8
) (
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    input wire logic [W-1:0] i_async,
    output logic [W-1:0] o_sync
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] val;
    } pmx_sync_s;
    pmx_sync_s st_r;
    pmx_sync_s st_nxt;

    always_comb begin
        st_nxt = st_r;
        st_nxt.s1 = i_async;
        st_nxt.s2 = st_r.s1;
        st_nxt.s3 = st_r.s2;
        // Accept a change only once two later stages agree
        for (int i = 0; i < W; i++) begin
            if (st_r.s2[i] == st_r.s3[i]) begin
                st_nxt.val[i] = st_r.s3[i];
            end
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign o_sync = st_r.val;
endmodule
